// ==== verilog/lpm_pkg.sv ====
/*
 * Package for the low-power mode controller: operating modes, register
 * offsets, control field positions and oscillator settling figures.
 * Assumes an 8-bit register port with a 4-bit word address.
 */
package lpm_pkg;

  typedef enum logic [3:0] {
    LPM_RESET,
    LPM_HIGH,
    LPM_MED,
    LPM_SUB,
    LPM_SLEEP,
    LPM_SUBSLEEP,
    LPM_WATCH,
    LPM_STANDBY,
    LPM_SETTLE
  } lpm_mode_t;

  // Wake-up requests, levels from the interrupt controller
  typedef struct packed {
    logic timer_a;
    logic timer_c;
    logic [4:0] ext;
    logic [7:0] wakeup;
  } lpm_wake_t;

  localparam int ADDR_W = 4;
  localparam int DATA_W = 8;

  localparam logic [3:0] OFS_SYS_ONE = 4'h0;
  localparam logic [3:0] OFS_SYS_TWO = 4'h1;
  localparam logic [3:0] OFS_TMR_A = 4'h2;
  localparam logic [3:0] OFS_IEN_ONE = 4'h3;
  localparam logic [3:0] OFS_IEN_WKP = 4'h4;
  localparam logic [3:0] OFS_IEN_TWO = 4'h5;
  localparam logic [3:0] OFS_STATUS = 4'h6;

  // system_control_one
  localparam int STANDBY_SELECT_BIT = 7;
  localparam int STS_HI = 6;
  localparam int STS_LO = 4;
  localparam int LOW_SPEED_ON_BIT = 3;
  // system_control_two
  localparam int DIRECT_TRANSFER_ON_BIT = 4;
  localparam int MEDIUM_SPEED_ON_BIT = 3;
  localparam int SDIV_HI = 1;
  localparam int SDIV_LO = 0;
  // timer_a_mode_reg
  localparam int WSEL_BIT = 3;
  // interrupt_enable_one
  localparam int IEN_TA_BIT = 0;
  localparam int IEN_TC_BIT = 1;
  localparam int IEN_EXT_LO = 2;
  localparam int IEN_EXT_HI = 6;
  // interrupt_enable_two
  localparam int IEN_DT_BIT = 0;

  localparam logic [7:0] RST_REG = 8'h00;

  // One settling state is one system clock cycle
  localparam int SETTLE_BASE_STATES = 8192;
  localparam logic [2:0] SETTLE_MAX_SHIFT = 3'h4;
  localparam int SETTLE_CNT_W = 18;
  localparam logic [2:0] MED_DIV_LAST = 3'h7;
  localparam logic [2:0] SUB_MASK_2 = 3'h1;
  localparam logic [2:0] SUB_MASK_4 = 3'h3;
  localparam logic [2:0] SUB_MASK_8 = 3'h7;

endpackage

// ==== verilog/lpm_ctrl.sv ====
/*
 * Low-power mode controller: mode state machine, CPU clock enables for
 * medium-speed and subactive operation, oscillator settling wait and the
 * control registers. Assumes the CPU pulses sleep_exec_i for one cycle per
 * SLEEP instruction and that all inputs are synchronous to sys_clk_i.
 */
// The address map and the strobed register port were chosen for this implementation.
// Contract
// - SLEEP in subactive, standby 0, low-speed 1, watch 1 enters subsleep.
// - Subsleep halts peripherals but timers A, C and display; keeps pins.
// - Subsleep ends on timer A/C, external, wakeup interrupt or reset pin.
// - No interrupt wake while global mask set or source disabled.
// - Watch goes to subactive on timer A, external 0 or wakeup if low-speed.
// - Subsleep goes to subactive on any enabled listed interrupt.
// - SLEEP in subactive with standby 1 and watch 1 enters watch.
// - Subactive clock is watch clock divided by 2, 4 or 8.
// - Medium-speed on, low-speed off: wake goes to medium-speed active.
// - SLEEP in medium-speed, standby 1, low-speed 0, watch 0: standby.
// - SLEEP in medium-speed with standby 1 and watch 1: watch.
// - SLEEP in medium-speed, standby and low-speed 0, no transfer: sleep.
// - Reset pin low in medium-speed resets CPU and leaves that mode.
// - Medium-speed CPU clock is one eighth of high-speed.
// - Direct transfer SLEEP switches executing modes, then transfer interrupt.
// - Transfer interrupt disabled: direct SLEEP lands in sleep or watch.
// - Transfer under global mask lands in sleep or watch, not wakeable.
// - High-speed direct SLEEP with medium on goes via sleep to medium.
// - Medium-speed direct SLEEP with medium off goes via sleep to high.
// - Active direct SLEEP, standby, low-speed, watch 1: via watch to sub.
// - Subactive direct SLEEP, medium off: via watch, settle, high-speed.
// - Subactive direct SLEEP, medium on: via watch, settle, medium-speed.
// - Settling wait is 8192 shifted by settling code, top bit 131072.
`timescale 1ns/1ps

module lpm_ctrl #(
  parameter int SETTLE_BASE = lpm_pkg::SETTLE_BASE_STATES
) (
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  input wire logic [lpm_pkg::ADDR_W-1:0] addr_i,
  input wire logic [lpm_pkg::DATA_W-1:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [lpm_pkg::DATA_W-1:0] rdata_o,
  input wire logic sleep_exec_i,
  input wire logic global_mask_i,
  input wire lpm_pkg::lpm_wake_t wake_i,
  input wire logic reset_pin_n_i,
  input wire logic watch_clk_i,
  output lpm_pkg::lpm_mode_t mode_o,
  output logic cpu_clk_en_o,
  output logic cpu_reset_o,
  output logic periph_halt_o,
  output logic io_hold_o,
  output logic io_hiz_o,
  output logic osc_run_o,
  output logic irq_start_o,
  output logic dt_irq_start_o
);
  ////////////////////////////////////////////////////////////////////////
  // Registers
  logic [7:0] sys_one, sys_two, tmr_a, ien_one, ien_wkp, ien_two;
  logic [7:0] next_sys_one, next_sys_two, next_tmr_a, next_ien_one;
  logic [7:0] next_ien_wkp, next_ien_two, next_rdata;
  lpm_pkg::lpm_mode_t mode;

  always_comb begin
    next_sys_one = sys_one;
    next_sys_two = sys_two;
    next_tmr_a = tmr_a;
    next_ien_one = ien_one;
    next_ien_wkp = ien_wkp;
    next_ien_two = ien_two;
    next_rdata = 8'h00;
    if (wr_i) begin
      case (addr_i)
        lpm_pkg::OFS_SYS_ONE: next_sys_one = wdata_i;
        lpm_pkg::OFS_SYS_TWO: next_sys_two = wdata_i;
        lpm_pkg::OFS_TMR_A: next_tmr_a = wdata_i;
        lpm_pkg::OFS_IEN_ONE: next_ien_one = wdata_i;
        lpm_pkg::OFS_IEN_WKP: next_ien_wkp = wdata_i;
        lpm_pkg::OFS_IEN_TWO: next_ien_two = wdata_i;
        default: ;
      endcase
    end
    if (rd_i) begin
      case (addr_i)
        lpm_pkg::OFS_SYS_ONE: next_rdata = sys_one;
        lpm_pkg::OFS_SYS_TWO: next_rdata = sys_two;
        lpm_pkg::OFS_TMR_A: next_rdata = tmr_a;
        lpm_pkg::OFS_IEN_ONE: next_rdata = ien_one;
        lpm_pkg::OFS_IEN_WKP: next_rdata = ien_wkp;
        lpm_pkg::OFS_IEN_TWO: next_rdata = ien_two;
        lpm_pkg::OFS_STATUS: next_rdata = {4'h0, mode};
        default: next_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sys_one <= lpm_pkg::RST_REG;
      sys_two <= lpm_pkg::RST_REG;
      tmr_a <= lpm_pkg::RST_REG;
      ien_one <= lpm_pkg::RST_REG;
      ien_wkp <= lpm_pkg::RST_REG;
      ien_two <= lpm_pkg::RST_REG;
      rdata_o <= lpm_pkg::RST_REG;
    end else begin
      sys_one <= next_sys_one;
      sys_two <= next_sys_two;
      tmr_a <= next_tmr_a;
      ien_one <= next_ien_one;
      ien_wkp <= next_ien_wkp;
      ien_two <= next_ien_two;
      rdata_o <= next_rdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Control decode and wake qualification
  logic standby_select, low_speed_on, medium_speed_on, direct_transfer_on, wsel, dt_ok;
  logic [2:0] sts;
  logic [1:0] sdiv;
  logic [4:0] ext_en;
  logic ext_hit, wkp_hit, ta_hit, tc_hit, wake_standby, wake_watch, wake_all;
  lpm_pkg::lpm_mode_t active_target;

  assign standby_select = sys_one[lpm_pkg::STANDBY_SELECT_BIT];
  assign low_speed_on = sys_one[lpm_pkg::LOW_SPEED_ON_BIT];
  assign sts = sys_one[lpm_pkg::STS_HI:lpm_pkg::STS_LO];
  assign medium_speed_on = sys_two[lpm_pkg::MEDIUM_SPEED_ON_BIT];
  assign direct_transfer_on = sys_two[lpm_pkg::DIRECT_TRANSFER_ON_BIT];
  assign sdiv = sys_two[lpm_pkg::SDIV_HI:lpm_pkg::SDIV_LO];
  assign wsel = tmr_a[lpm_pkg::WSEL_BIT];
  assign ext_en = ien_one[lpm_pkg::IEN_EXT_HI:lpm_pkg::IEN_EXT_LO];
  assign dt_ok = direct_transfer_on && ien_two[lpm_pkg::IEN_DT_BIT] && !global_mask_i;
  // Only enabled sources count, and none while masked
  assign ta_hit = wake_i.timer_a && ien_one[lpm_pkg::IEN_TA_BIT] && !global_mask_i;
  assign tc_hit = wake_i.timer_c && ien_one[lpm_pkg::IEN_TC_BIT] && !global_mask_i;
  assign ext_hit = |(wake_i.ext & ext_en) && !global_mask_i;
  assign wkp_hit = |(wake_i.wakeup & ien_wkp) && !global_mask_i;
  assign wake_standby = |(wake_i.ext[1:0] & ext_en[1:0]) && !global_mask_i || wkp_hit;
  assign wake_watch = ta_hit || (wake_i.ext[0] && ext_en[0] && !global_mask_i) || wkp_hit;
  assign wake_all = ta_hit || tc_hit || ext_hit || wkp_hit;
  assign active_target = (medium_speed_on && !low_speed_on) ? lpm_pkg::LPM_MED : lpm_pkg::LPM_HIGH;
  ////////////////////////////////////////////////////////////////////////
  // Settling load
  logic [2:0] sts_shift;
  logic [lpm_pkg::SETTLE_CNT_W-1:0] settle_load;

  always_comb begin
    sts_shift = sts[2] ? lpm_pkg::SETTLE_MAX_SHIFT : {1'b0, sts[1:0]};
    settle_load = (lpm_pkg::SETTLE_CNT_W'(SETTLE_BASE) << sts_shift)
      - lpm_pkg::SETTLE_CNT_W'(1);
  end
  ////////////////////////////////////////////////////////////////////////
  // Mode state machine
  lpm_pkg::lpm_mode_t next_mode, target, next_target;
  logic dt, next_dt, next_irq, next_dtirq;
  logic [lpm_pkg::SETTLE_CNT_W-1:0] cnt, next_cnt;
  always_comb begin
    next_mode = mode;
    next_target = target;
    next_dt = dt;
    next_cnt = cnt;
    next_irq = 1'b0;
    next_dtirq = 1'b0;
    if (!reset_pin_n_i) begin
      next_mode = lpm_pkg::LPM_RESET;
      next_dt = 1'b0;
    end else begin
      case (mode)
        lpm_pkg::LPM_RESET: next_mode = lpm_pkg::LPM_HIGH;
        lpm_pkg::LPM_HIGH, lpm_pkg::LPM_MED: begin
          if (sleep_exec_i) begin
            if (dt_ok && !standby_select && !low_speed_on) begin
              next_mode = lpm_pkg::LPM_SLEEP;
              next_dt = 1'b1;
              next_target = medium_speed_on ? lpm_pkg::LPM_MED : lpm_pkg::LPM_HIGH;
            end else if (dt_ok && standby_select && low_speed_on && wsel) begin
              next_mode = lpm_pkg::LPM_WATCH;
              next_dt = 1'b1;
              next_target = lpm_pkg::LPM_SUB;
            end else if (!standby_select) begin
              next_mode = lpm_pkg::LPM_SLEEP;
            end else if (wsel) begin
              next_mode = lpm_pkg::LPM_WATCH;
            end else if (!low_speed_on) begin
              next_mode = lpm_pkg::LPM_STANDBY;
            end
          end
        end
        lpm_pkg::LPM_SUB: begin
          if (sleep_exec_i && wsel) begin
            if (!standby_select && low_speed_on) begin
              next_mode = lpm_pkg::LPM_SUBSLEEP;
            end else if (standby_select) begin
              next_mode = lpm_pkg::LPM_WATCH;
              if (dt_ok && !low_speed_on) begin
                next_dt = 1'b1;
                next_target = medium_speed_on ? lpm_pkg::LPM_MED : lpm_pkg::LPM_HIGH;
              end
            end
          end
        end
        lpm_pkg::LPM_SLEEP: begin
          if (dt) begin
            next_mode = target;
            next_dt = 1'b0;
            next_dtirq = 1'b1;
          end else if (wake_all) begin
            next_mode = active_target;
            next_irq = 1'b1;
          end
        end
        lpm_pkg::LPM_WATCH: begin
          if (dt && target == lpm_pkg::LPM_SUB) begin
            next_mode = lpm_pkg::LPM_SUB;
            next_dt = 1'b0;
            next_dtirq = 1'b1;
          end else if (dt) begin
            next_mode = lpm_pkg::LPM_SETTLE;
            next_cnt = settle_load;
          end else if (wake_watch && low_speed_on) begin
            next_mode = lpm_pkg::LPM_SUB;
            next_irq = 1'b1;
          end else if (wake_watch) begin
            next_mode = lpm_pkg::LPM_SETTLE;
            next_target = active_target;
            next_cnt = settle_load;
          end
        end
        lpm_pkg::LPM_STANDBY: begin
          if (wake_standby) begin
            next_mode = lpm_pkg::LPM_SETTLE;
            next_target = active_target;
            next_cnt = settle_load;
          end
        end
        lpm_pkg::LPM_SUBSLEEP: begin
          if (wake_all) begin
            next_mode = lpm_pkg::LPM_SUB;
            next_irq = 1'b1;
          end
        end
        lpm_pkg::LPM_SETTLE: begin
          if (cnt == '0) begin
            next_mode = target;
            next_dt = 1'b0;
            next_dtirq = dt;
            next_irq = !dt;
          end else begin
            next_cnt = cnt - lpm_pkg::SETTLE_CNT_W'(1);
          end
        end
        default: next_mode = lpm_pkg::LPM_RESET;
      endcase
    end
  end

  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      mode <= lpm_pkg::LPM_RESET;
      target <= lpm_pkg::LPM_HIGH;
      dt <= 1'b0;
      cnt <= '0;
      irq_start_o <= 1'b0;
      dt_irq_start_o <= 1'b0;
    end else begin
      mode <= next_mode;
      target <= next_target;
      dt <= next_dt;
      cnt <= next_cnt;
      irq_start_o <= next_irq;
      dt_irq_start_o <= next_dtirq;
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // CPU clock enables and mode outputs
  logic [2:0] med_cnt, next_med_cnt, sub_cnt, next_sub_cnt, sub_mask;
  logic watch_q, watch_edge, sub_tick;
  logic next_clk_en, next_cpu_rst, next_halt, next_hold, next_hiz, next_osc;
  always_comb begin
    watch_edge = watch_clk_i && !watch_q;
    case (sdiv)
      2'h0: sub_mask = lpm_pkg::SUB_MASK_2;
      2'h1: sub_mask = lpm_pkg::SUB_MASK_4;
      default: sub_mask = lpm_pkg::SUB_MASK_8;
    endcase
    sub_tick = watch_edge && ((sub_cnt & sub_mask) == sub_mask);
    next_sub_cnt = watch_edge ? sub_cnt + 3'h1 : sub_cnt;
    next_med_cnt = med_cnt + 3'h1;
    case (next_mode)
      lpm_pkg::LPM_HIGH: next_clk_en = 1'b1;
      lpm_pkg::LPM_MED: next_clk_en = (med_cnt == lpm_pkg::MED_DIV_LAST);
      lpm_pkg::LPM_SUB: next_clk_en = sub_tick;
      default: next_clk_en = 1'b0;
    endcase
    next_cpu_rst = (next_mode == lpm_pkg::LPM_RESET);
    next_halt = next_mode inside {lpm_pkg::LPM_STANDBY, lpm_pkg::LPM_WATCH,
      lpm_pkg::LPM_SUBSLEEP};
    next_hold = next_mode inside {lpm_pkg::LPM_WATCH, lpm_pkg::LPM_SUBSLEEP};
    next_hiz = (next_mode == lpm_pkg::LPM_STANDBY);
    next_osc = next_mode inside {lpm_pkg::LPM_RESET, lpm_pkg::LPM_HIGH, lpm_pkg::LPM_MED,
      lpm_pkg::LPM_SLEEP, lpm_pkg::LPM_SETTLE};
  end

  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      med_cnt <= 3'h0;
      sub_cnt <= 3'h0;
      watch_q <= 1'b0;
      cpu_clk_en_o <= 1'b0;
      cpu_reset_o <= 1'b1;
      periph_halt_o <= 1'b0;
      io_hold_o <= 1'b0;
      io_hiz_o <= 1'b0;
      osc_run_o <= 1'b1;
    end else begin
      med_cnt <= next_med_cnt;
      sub_cnt <= next_sub_cnt;
      watch_q <= watch_clk_i;
      cpu_clk_en_o <= next_clk_en;
      cpu_reset_o <= next_cpu_rst;
      periph_halt_o <= next_halt;
      io_hold_o <= next_hold;
      io_hiz_o <= next_hiz;
      osc_run_o <= next_osc;
    end
  end

  assign mode_o = mode;
  ////////////////////////////////////////////////////////////////////////
  // Assertions
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!nrst_i);

  sequence s_sleep_in(lpm_pkg::lpm_mode_t m);
    mode == m && sleep_exec_i && reset_pin_n_i;
  endsequence
  sequence s_dt_via_sleep;
    mode == lpm_pkg::LPM_SLEEP && dt ##1 dt_irq_start_o;
  endsequence
  a_subsleep_entry: assert property (s_sleep_in(lpm_pkg::LPM_SUB) and ##0 (!standby_select && low_speed_on && wsel)
    |=> mode == lpm_pkg::LPM_SUBSLEEP) else $error("subsleep not entered");
  a_subsleep_hold: assert property (mode == lpm_pkg::LPM_SUBSLEEP |-> periph_halt_o && io_hold_o
    && !io_hiz_o && !cpu_clk_en_o) else $error("subsleep outputs wrong");
  a_reset_pin: assert property (!reset_pin_n_i |=> mode == lpm_pkg::LPM_RESET && cpu_reset_o)
    else $error("reset pin ignored");
  a_mask_holds: assert property (mode == lpm_pkg::LPM_SUBSLEEP && global_mask_i
    && reset_pin_n_i |=> mode == lpm_pkg::LPM_SUBSLEEP) else $error("masked wake");
  a_subsleep_wake: assert property (mode == lpm_pkg::LPM_SUBSLEEP && reset_pin_n_i && wake_all
    |=> mode == lpm_pkg::LPM_SUB && irq_start_o) else $error("subsleep wake lost");
  a_watch_sub: assert property (mode == lpm_pkg::LPM_WATCH && !dt && low_speed_on && wake_watch
    && reset_pin_n_i |=> mode == lpm_pkg::LPM_SUB) else $error("watch wake wrong");
  a_standby_entry: assert property (s_sleep_in(lpm_pkg::LPM_MED) and ##0 (standby_select && !low_speed_on
    && !wsel) |=> mode == lpm_pkg::LPM_STANDBY) else $error("standby not entered");
  a_med_divide: assert property ((mode == lpm_pkg::LPM_MED && cpu_clk_en_o)
    ##1 (mode == lpm_pkg::LPM_MED && !cpu_clk_en_o)[*7]
    |=> mode != lpm_pkg::LPM_MED || cpu_clk_en_o) else $error("medium clock ratio");
  a_dt_to_med: assert property (s_sleep_in(lpm_pkg::LPM_HIGH) and ##0 (dt_ok && !standby_select
    && !low_speed_on && medium_speed_on) |=> s_dt_via_sleep ##0 mode == lpm_pkg::LPM_MED)
    else $error("direct transfer failed");
  a_settle_end: assert property (mode == lpm_pkg::LPM_SETTLE && cnt == '0 && reset_pin_n_i
    |=> mode == $past(target) && (irq_start_o || dt_irq_start_o))
    else $error("settle exit wrong");

endmodule // lpm_ctrl

// ==== tb/test_low_power_mode_controller.sv ====
/*
 * Self-checking bench for the low-power mode controller: register access,
 * mode transitions, wake qualification, settling counts and clock enables.
 * Assumes the controller is built with a small settling base for speed.
 */
`timescale 1ns/1ps

module test_low_power_mode_controller;
  localparam int SB = 4;
  logic sys_clk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic sleep_exec_i = 1'b0;
  logic global_mask_i = 1'b0;
  logic reset_pin_n_i = 1'b1;
  logic watch_clk_i = 1'b0;
  logic [3:0] addr_i = 4'h0;
  logic [7:0] wdata_i = 8'h00;
  logic [7:0] rdata_o;
  lpm_pkg::lpm_wake_t wake_i = '0;
  lpm_pkg::lpm_mode_t mode_o;
  logic cpu_clk_en_o, cpu_reset_o, periph_halt_o, io_hold_o, io_hiz_o;
  logic osc_run_o, irq_start_o, dt_irq_start_o;
  logic [1:0] wdiv = 2'h0;
  int fail_count = 0;
  int checked = 0;
  int cycles = 0;
  int n;

  lpm_ctrl #(.SETTLE_BASE(SB)) i_lpm_ctrl (
    .sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .sleep_exec_i(sleep_exec_i),
    .global_mask_i(global_mask_i), .wake_i(wake_i), .reset_pin_n_i(reset_pin_n_i),
    .watch_clk_i(watch_clk_i), .mode_o(mode_o), .cpu_clk_en_o(cpu_clk_en_o),
    .cpu_reset_o(cpu_reset_o), .periph_halt_o(periph_halt_o), .io_hold_o(io_hold_o),
    .io_hiz_o(io_hiz_o), .osc_run_o(osc_run_o), .irq_start_o(irq_start_o),
    .dt_irq_start_o(dt_irq_start_o)
  );

  always #2 sys_clk_i = ~sys_clk_i;

  // Watch clock: one rising edge every 8 system cycles
  always @(posedge sys_clk_i) begin
    wdiv <= wdiv + 2'h1;
    if (wdiv == 2'h3) begin
      watch_clk_i <= ~watch_clk_i;
    end
    cycles <= cycles + 1;
    if (cycles == 6000) begin
      fail_count++;
      $display("[ERR] %0t run did not finish", $time);
      report_and_stop();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic chk_mode(input lpm_pkg::lpm_mode_t m);
    chk({4'h0, mode_o}, {4'h0, m}, "mode");
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge sys_clk_i);
    wr_i <= 1'b1;
    addr_i <= a;
    wdata_i <= d;
    @(posedge sys_clk_i);
    wr_i <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, input logic [7:0] exp);
    @(posedge sys_clk_i);
    rd_i <= 1'b1;
    addr_i <= a;
    @(posedge sys_clk_i);
    rd_i <= 1'b0;
    #1;
    chk(rdata_o, exp, "read data");
  endtask

  task automatic sleep_to(input lpm_pkg::lpm_mode_t m);
    @(posedge sys_clk_i);
    sleep_exec_i <= 1'b1;
    @(posedge sys_clk_i);
    sleep_exec_i <= 1'b0;
    #1;
    chk_mode(m);
  endtask

  task automatic step(input lpm_pkg::lpm_mode_t m);
    @(posedge sys_clk_i);
    #1;
    chk_mode(m);
  endtask

  // Already in SETTLE: n cycles there in all, then target with a pulse
  task automatic settle_to(input int cnt, input lpm_pkg::lpm_mode_t m, input logic dt);
    repeat (cnt - 1) step(lpm_pkg::LPM_SETTLE);
    step(m);
    chk(dt ? dt_irq_start_o : irq_start_o, 8'h01, "start pulse");
  endtask

  task automatic wake_go(input logic [14:0] w, input lpm_pkg::lpm_mode_t m);
    int i;
    @(posedge sys_clk_i);
    wake_i <= w;
    @(posedge sys_clk_i);
    #1;
    for (i = 0; i < 200 && mode_o !== m; i++) begin
      @(posedge sys_clk_i);
      #1;
    end
    chk_mode(m);
    chk(irq_start_o, 8'h01, "wake pulse");
    @(posedge sys_clk_i);
    wake_i <= '0;
    #1;
    chk(irq_start_o, 8'h00, "wake pulse ends");
  endtask

  // Wake attempt that must not be honoured
  task automatic wake_no(input logic [14:0] w, input logic msk, input lpm_pkg::lpm_mode_t m);
    @(posedge sys_clk_i);
    wake_i <= w;
    global_mask_i <= msk;
    repeat (8) @(posedge sys_clk_i);
    wake_i <= '0;
    global_mask_i <= 1'b0;
    #1;
    chk_mode(m);
  endtask

  task automatic count_en(input int cyc, input int exp);
    int c;
    c = 0;
    repeat (cyc) begin
      @(posedge sys_clk_i);
      #1;
      if (cpu_clk_en_o === 1'b1) begin
        c++;
      end
    end
    chk(c[7:0], exp[7:0], "clock enable count");
  endtask

  task automatic pin_reset();
    @(posedge sys_clk_i);
    reset_pin_n_i <= 1'b0;
    @(posedge sys_clk_i);
    reset_pin_n_i <= 1'b1;
    #1;
    chk_mode(lpm_pkg::LPM_RESET);
    chk(cpu_reset_o, 8'h01, "cpu reset");
    step(lpm_pkg::LPM_HIGH);
    chk(cpu_reset_o, 8'h00, "cpu reset released");
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (10) @(posedge sys_clk_i);
    nrst_i <= 1'b1;
    step(lpm_pkg::LPM_HIGH);
    chk(cpu_clk_en_o, 8'h01, "high speed enable");
    for (n = 0; n < 6; n++) rd(n[3:0], 8'h00);
    rd(4'h6, 8'h01);
    rd(4'hf, 8'h00);
    // Direct request with its interrupt disabled
    wr(4'h1, 8'h10);
    sleep_to(lpm_pkg::LPM_SLEEP);
    step(lpm_pkg::LPM_SLEEP);
    chk(dt_irq_start_o, 8'h00, "no transfer pulse");
    wr(4'h3, 8'h02);
    wake_go(15'h2000, lpm_pkg::LPM_HIGH);
    // High to medium and back
    wr(4'h1, 8'h18);
    wr(4'h5, 8'h01);
    sleep_to(lpm_pkg::LPM_SLEEP);
    step(lpm_pkg::LPM_MED);
    chk(dt_irq_start_o, 8'h01, "transfer pulse");
    count_en(32, 4);
    wr(4'h1, 8'h10);
    sleep_to(lpm_pkg::LPM_SLEEP);
    step(lpm_pkg::LPM_HIGH);
    chk(dt_irq_start_o, 8'h01, "transfer pulse");
    count_en(16, 16);
    wr(4'h1, 8'h18);
    sleep_to(lpm_pkg::LPM_SLEEP);
    step(lpm_pkg::LPM_MED);
    // Sleep from medium speed, wake qualification
    wr(4'h1, 8'h08);
    sleep_to(lpm_pkg::LPM_SLEEP);
    wake_no(15'h2000, 1'b1, lpm_pkg::LPM_SLEEP);
    wake_no(15'h1000, 1'b0, lpm_pkg::LPM_SLEEP);
    wake_go(15'h2000, lpm_pkg::LPM_MED);
    // Standby, settling code 2
    wr(4'h0, 8'ha0);
    sleep_to(lpm_pkg::LPM_STANDBY);
    chk({io_hiz_o, osc_run_o}, 8'h02, "standby pins");
    wr(4'h3, 8'h05);
    @(posedge sys_clk_i);
    wake_i <= 15'h0100;
    @(posedge sys_clk_i);
    wake_i <= '0;
    #1;
    chk_mode(lpm_pkg::LPM_SETTLE);
    settle_to(SB << 2, lpm_pkg::LPM_MED, 1'b0);
    // Watch from medium speed, timer A wake
    wr(4'h2, 8'h08);
    wr(4'h0, 8'h80);
    sleep_to(lpm_pkg::LPM_WATCH);
    chk({periph_halt_o, io_hold_o}, 8'h03, "watch pins");
    wake_go(15'h4000, lpm_pkg::LPM_MED);
    // Medium to subactive via watch, then divider choices
    wr(4'h0, 8'h88);
    wr(4'h1, 8'h10);
    sleep_to(lpm_pkg::LPM_WATCH);
    step(lpm_pkg::LPM_SUB);
    chk(dt_irq_start_o, 8'h01, "transfer pulse");
    rd(4'h6, 8'h03);
    for (n = 0; n < 4; n++) begin
      wr(4'h1, 8'h10 | n[7:0]);
      repeat (16) @(posedge sys_clk_i);
      count_en(64, (n == 0) ? 4 : (n == 1) ? 2 : 1);
    end
    // Subsleep and its wakes
    wr(4'h1, 8'h00);
    wr(4'h0, 8'h08);
    sleep_to(lpm_pkg::LPM_SUBSLEEP);
    chk({periph_halt_o, io_hold_o, io_hiz_o}, 8'h06, "subsleep pins");
    wake_no(15'h0080, 1'b0, lpm_pkg::LPM_SUBSLEEP);
    wr(4'h4, 8'h80);
    wake_no(15'h0080, 1'b1, lpm_pkg::LPM_SUBSLEEP);
    wake_go(15'h0080, lpm_pkg::LPM_SUB);
    // Watch from subactive, external 0 wake with low speed on
    wr(4'h0, 8'h88);
    sleep_to(lpm_pkg::LPM_WATCH);
    wake_go(15'h0100, lpm_pkg::LPM_SUB);
    // Subactive to medium, settling code with top bit set
    wr(4'h0, 8'hd0);
    wr(4'h1, 8'h18);
    sleep_to(lpm_pkg::LPM_WATCH);
    step(lpm_pkg::LPM_SETTLE);
    settle_to(SB << 4, lpm_pkg::LPM_MED, 1'b1);
    wr(4'h0, 8'h88);
    wr(4'h1, 8'h10);
    sleep_to(lpm_pkg::LPM_WATCH);
    step(lpm_pkg::LPM_SUB);
    wr(4'h0, 8'h80);
    sleep_to(lpm_pkg::LPM_WATCH);
    step(lpm_pkg::LPM_SETTLE);
    settle_to(SB, lpm_pkg::LPM_HIGH, 1'b1);
    // Direct request under global mask sticks in sleep
    wr(4'h0, 8'h00);
    @(posedge sys_clk_i);
    global_mask_i <= 1'b1;
    sleep_to(lpm_pkg::LPM_SLEEP);
    wake_no(15'h2000, 1'b1, lpm_pkg::LPM_SLEEP);
    pin_reset();
    // Reset pin during medium speed
    wr(4'h1, 8'h18);
    sleep_to(lpm_pkg::LPM_SLEEP);
    step(lpm_pkg::LPM_MED);
    pin_reset();
    report_and_stop();
  end
endmodule // test_low_power_mode_controller
